// File: sqdiv_pkg.sv
// package for the square-wave divider channel: register map, control word
// fields, counter constants, state encoding and bus carriers.
// assumes a single 100 MHz ref_clk domain and an axi4-lite master.
package sqdiv_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] LOAD_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;

    // ****************************************************************
    // control word fields and reset values
    // ****************************************************************
    localparam int CTRL_SEL_LSB = 6;
    localparam int CTRL_ACC_LSB = 4;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_BCD_BIT = 0;
    localparam logic [1:0] SEL_COUNTER0 = 2'h0;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LOW = 2'h1;
    localparam logic [1:0] ACC_HIGH = 2'h2;
    localparam logic [1:0] ACC_BOTH = 2'h3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic OUT_RST = 1'b1;

    // ****************************************************************
    // status register fields
    // ****************************************************************
    localparam int ST_OUT_BIT = 0;
    localparam int ST_VALID_BIT = 1;
    localparam int ST_PTR_BIT = 2;
    localparam int ST_GATE_BIT = 3;
    localparam int ST_PEND_BIT = 4;
    localparam int ST_CNT_LSB = 16;

    // ****************************************************************
    // counter constants
    // ****************************************************************
    localparam logic [15:0] CNT_STEP = 16'h0002;
    localparam logic [15:0] CNT_HALF_END = 16'h0002;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    // ****************************************************************
    // bus responses
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SQDIV_IDLE,
        SQDIV_ARMED,
        SQDIV_LOAD,
        SQDIV_RUN
    } sqdiv_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } sqdiv_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } sqdiv_axil_rsp_t;

endpackage : sqdiv_pkg

// File: sqdiv_sync.sv
// two-flop synchroniser for one level coming from a pin.
// assumes the pin is asynchronous to ref_clk.
`timescale 1ns/100ps
module sqdiv_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level_out
);
    import sqdiv_pkg::*;

    logic meta_q;
    logic meta_d;
    logic level_q;
    logic level_d;

    always_comb begin
        meta_d = pin_in;
        level_d = meta_q;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            level_q <= level_d;
        end
    end

    assign level_out = level_q;

endmodule : sqdiv_sync

// File: sqdiv_axil_slave.sv
// axi4-lite slave front end: turns bus writes into a one-cycle write
// strobe and answers reads from a combinational read port.
// assumes the register owner decodes addresses and reports errors.
`timescale 1ns/100ps
module sqdiv_axil_slave (
    input wire logic ref_clk,
    input wire logic reset,
    input wire sqdiv_pkg::sqdiv_axil_req_t axil_req,
    output sqdiv_pkg::sqdiv_axil_rsp_t axil_rsp,
    output logic wr_en,
    output logic [sqdiv_pkg::ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [sqdiv_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    import sqdiv_pkg::*;

    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic aw_rdy, w_rdy, ar_rdy;

    // ****************************************************************
    // channel handshakes
    // ****************************************************************
    // address and data are taken in either order and held until the
    // strobe fires; no new write is taken until the response is gone
    always_comb begin
        aw_rdy = !aw_have_q && !bvalid_q;
        w_rdy = !w_have_q && !bvalid_q;
        ar_rdy = !rvalid_q;
        wr_en = aw_have_q && w_have_q && !bvalid_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (axil_req.awvalid && aw_rdy) begin
            aw_have_d = 1'b1;
            awaddr_d = axil_req.awaddr;
        end
        if (axil_req.wvalid && w_rdy) begin
            w_have_d = 1'b1;
            wdata_d = axil_req.wdata;
            wstrb_d = axil_req.wstrb;
        end
        if (wr_en) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid_q && axil_req.bready) begin
            bvalid_d = 1'b0;
        end
        if (axil_req.arvalid && ar_rdy) begin
            rvalid_d = 1'b1;
            rdata_d = rd_data;
            rresp_d = rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_q && axil_req.rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    always_comb begin
        axil_rsp.awready = aw_rdy;
        axil_rsp.wready = w_rdy;
        axil_rsp.bresp = bresp_q;
        axil_rsp.bvalid = bvalid_q;
        axil_rsp.arready = ar_rdy;
        axil_rsp.rdata = rdata_q;
        axil_rsp.rresp = rresp_q;
        axil_rsp.rvalid = rvalid_q;
    end

    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;
    assign wr_strb = wstrb_q;
    assign rd_addr = axil_req.araddr;

endmodule : sqdiv_axil_slave

// File: sqdiv_channel.sv
// square-wave divider channel: control word, byte-wise count loading,
// gate handling and the step-by-two down counter that drives the output.
// assumes ref_clk is the counting clock and count_gate is an async pin.
`timescale 1ns/100ps

// Notes on behaviour
// R1 - gate high lets the counter step; gate low freezes it
// R2 - a gate rising edge reloads the counter on the next clock
// R3 - a count written mid-run leaves the current half period alone
// R4 - a count written mid-run loads only when the half period ends; a gate trigger before then also loads it
// R5 - loading such a new count forces the output high
// R6 - first complete count after mode setting loads on the next clock
// R7 - each half period ends with a reload and an output toggle
// R8 - even count N loads N and steps down by two
// R9 - reaching 2 reloads on the next clock and inverts the output
// R10 - odd count N loads N-1 and still steps by two
// R11 - odd count: high half runs down to 0 before reloading
// R12 - odd count: low half ends at 2, one clock shorter
// R13 - the counter reaches zero only for odd counts
// R14 - gate triggers ignored until a whole count has been written
// R15 - host writes control word, then low byte, then high byte
// R16 - output starts high after mode setting, before any load
// R17 - host programs counts of two or more
// R18 - full period is N clocks, split per the even and odd rules
module sqdiv_channel (
    input wire logic ref_clk,
    input wire logic reset,
    input wire sqdiv_pkg::sqdiv_axil_req_t axil_req,
    output sqdiv_pkg::sqdiv_axil_rsp_t axil_rsp,
    input wire logic count_gate,
    output logic timer_output
);
    import sqdiv_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // even n loads n, odd n loads n-1
    function automatic logic [15:0] load_value(input logic [15:0] n);
        load_value = {n[15:1], 1'b0}; // R8 R10
    endfunction : load_value

    function automatic logic reg_known(input logic [ADDR_W-1:0] a,
                                       input logic is_write);
        reg_known = (a == CTRL_OFFSET) || (a == LOAD_OFFSET) ||
                    (!is_write && (a == STATUS_OFFSET));
    endfunction : reg_known

    logic wr_en, wr_err, rd_err;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic gate_s, gate_prev_q, gate_prev_d, gate_rise;

    sqdiv_axil_slave u_bus (
        .ref_clk(ref_clk),
        .reset(reset),
        .axil_req(axil_req),
        .axil_rsp(axil_rsp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    sqdiv_sync u_gate_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(count_gate),
        .level_out(gate_s)
    );

    // ****************************************************************
    // state
    // ****************************************************************
    sqdiv_state_t state_q, state_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] lsb_q, lsb_d;
    logic [15:0] count_q, count_d;
    logic [15:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic odd_q, odd_d;
    logic ptr_q, ptr_d;
    logic valid_q, valid_d;
    logic pend_q, pend_d;

    logic ctrl_wr, cnt_wr, cnt_complete, count_ok, trig, half_end;
    logic [1:0] acc;
    logic [15:0] load_val;

    always_comb begin
        gate_rise = gate_s && !gate_prev_q;
        gate_prev_d = gate_s;
        acc = ctrl_q[CTRL_ACC_LSB +: 2];
        ctrl_wr = wr_en && wr_strb[0] && (wr_addr == CTRL_OFFSET) &&
                  (wr_data[CTRL_SEL_LSB +: 2] == SEL_COUNTER0) &&
                  (wr_data[CTRL_ACC_LSB +: 2] != ACC_LATCH);
        cnt_wr = wr_en && wr_strb[0] && (wr_addr == LOAD_OFFSET) &&
                 (state_q != SQDIV_IDLE);
        cnt_complete = cnt_wr && ((acc != ACC_BOTH) || ptr_q);
        // a half-written count does not arm the trigger
        count_ok = valid_q && !ptr_q; // R14
        trig = gate_rise && count_ok && (state_q == SQDIV_RUN); // R14
        load_val = load_value(count_q);
        // odd counts keep the high half going one more step, down to 0
        half_end = ((cnt_q == CNT_HALF_END) && !(odd_q && out_q)) ||
                   (cnt_q == CNT_ZERO); // R9 R11 R12 R18
        wr_err = !reg_known(wr_addr, 1'b1);
        rd_err = !reg_known(rd_addr, 1'b0);
    end

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        ctrl_d = ctrl_q;
        lsb_d = lsb_q;
        count_d = count_q;
        cnt_d = cnt_q;
        out_d = out_q;
        odd_d = odd_q;
        ptr_d = ptr_q;
        valid_d = valid_q;
        pend_d = pend_q;
        case (state_q)
            SQDIV_LOAD: begin
                cnt_d = load_val; // R6
                odd_d = count_q[0]; // R10
                out_d = 1'b1;
                state_d = SQDIV_RUN;
            end
            SQDIV_RUN: begin
                if (trig) begin
                    cnt_d = load_val; // R2
                    odd_d = count_q[0];
                    out_d = 1'b1;
                    pend_d = 1'b0;
                end else if (gate_s) begin // R1
                    if (half_end) begin
                        cnt_d = load_val; // R7 R9 R11
                        odd_d = count_q[0];
                        pend_d = 1'b0;
                        // a fresh count starts on a high half
                        out_d = pend_q ? 1'b1 : !out_q; // R5 R7
                    end else begin
                        cnt_d = cnt_q - CNT_STEP; // R8 R10 R3
                    end
                end
            end
            SQDIV_IDLE, SQDIV_ARMED: begin
            end
            default: begin
                state_d = SQDIV_IDLE;
            end
        endcase
        if (cnt_wr) begin
            case (acc)
                ACC_LOW: count_d = {8'h00, wr_data[7:0]};
                ACC_HIGH: count_d = {wr_data[7:0], 8'h00};
                default: begin
                    if (!ptr_q) begin
                        lsb_d = wr_data[7:0]; // R15
                        ptr_d = 1'b1;
                    end else begin
                        count_d = {wr_data[7:0], lsb_q};
                        ptr_d = 1'b0;
                    end
                end
            endcase
            if (cnt_complete) begin
                valid_d = 1'b1;
                if (state_q == SQDIV_ARMED) begin
                    state_d = SQDIV_LOAD; // R6
                end else begin
                    pend_d = 1'b1; // R4
                end
            end
        end
        // mode setting restarts the channel and wins over the state, output and flag updates, but not the counter step or reload
        if (ctrl_wr) begin
            ctrl_d = wr_data[7:0];
            state_d = SQDIV_ARMED;
            out_d = 1'b1; // R16
            ptr_d = 1'b0;
            valid_d = 1'b0;
            pend_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= SQDIV_IDLE;
            ctrl_q <= CTRL_RST;
            lsb_q <= 8'h00;
            count_q <= COUNT_RST;
            cnt_q <= COUNT_RST;
            out_q <= OUT_RST;
            odd_q <= 1'b0;
            ptr_q <= 1'b0;
            valid_q <= 1'b0;
            pend_q <= 1'b0;
            gate_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            lsb_q <= lsb_d;
            count_q <= count_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            odd_q <= odd_d;
            ptr_q <= ptr_d;
            valid_q <= valid_d;
            pend_q <= pend_d;
            gate_prev_q <= gate_prev_d;
        end
    end

    assign timer_output = out_q;

    // ****************************************************************
    // register read port
    // ****************************************************************
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            CTRL_OFFSET: rd_data[7:0] = ctrl_q;
            LOAD_OFFSET: rd_data[15:0] = count_q;
            STATUS_OFFSET: begin
                rd_data[ST_OUT_BIT] = out_q;
                rd_data[ST_VALID_BIT] = valid_q;
                rd_data[ST_PTR_BIT] = ptr_q;
                rd_data[ST_GATE_BIT] = gate_s;
                rd_data[ST_PEND_BIT] = pend_q;
                rd_data[ST_CNT_LSB +: 16] = cnt_q;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic run_q;
    assign run_q = (state_q == SQDIV_RUN) && !ctrl_wr;

    gate_hold_a: assert property ( // R1
        @(posedge ref_clk) disable iff (reset)
        (run_q && !gate_s && !trig) |=> (cnt_q == $past(cnt_q)))
        else $error("counter moved while gate was low");

    trig_reload_a: assert property ( // R2
        @(posedge ref_clk) disable iff (reset)
        (run_q && trig) |=> (cnt_q == $past(load_val)) && out_q)
        else $error("gate trigger did not reload the counter");

    step_two_a: assert property ( // R3
        @(posedge ref_clk) disable iff (reset)
        (run_q && gate_s && !trig && !half_end) |=>
            (cnt_q == $past(cnt_q) - CNT_STEP) && (out_q == $past(out_q)))
        else $error("counter did not step by two mid half period");

    new_count_high_a: assert property ( // R5
        @(posedge ref_clk) disable iff (reset)
        (run_q && gate_s && !trig && half_end && pend_q) |=>
            out_q && (pend_q == $past(cnt_complete)) &&
            (cnt_q == $past(load_val)))
        else $error("pending count not loaded high at half end");

    first_load_a: assert property ( // R6
        @(posedge ref_clk) disable iff (reset)
        (state_q == SQDIV_ARMED && cnt_complete && !ctrl_wr) |=>
            (state_q == SQDIV_LOAD) ##1
            (state_q == SQDIV_RUN) && out_q && (cnt_q == $past(load_val)))
        else $error("first count not loaded on the next clock");

    half_toggle_a: assert property ( // R7
        @(posedge ref_clk) disable iff (reset)
        (run_q && gate_s && !trig && half_end && !pend_q) |=>
            (out_q != $past(out_q)) && (cnt_q == $past(load_val)))
        else $error("half period end without reload and toggle");

    zero_odd_a: assert property ( // R13
        @(posedge ref_clk) disable iff (reset)
        (state_q == SQDIV_RUN && cnt_q == CNT_ZERO) |->
            odd_q && out_q)
        else $error("counter reached zero with an even count");

    trig_ignored_a: assert property ( // R14
        @(posedge ref_clk) disable iff (reset)
        (state_q == SQDIV_ARMED && !cnt_complete && !ctrl_wr) |=>
            (state_q == SQDIV_ARMED))
        else $error("channel started without a whole count");

    mode_out_high_a: assert property ( // R16
        @(posedge ref_clk) disable iff (reset)
        ctrl_wr |=> out_q && (state_q == SQDIV_ARMED) && !valid_q)
        else $error("output not high after mode setting");

endmodule : sqdiv_channel

// File: sqdiv_host_model.sv
// host processor model: an axi4-lite master that programs the channel.
// assumes ref_clk and reset are shared with the channel it drives.
`timescale 1ns/100ps
module sqdiv_host_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire sqdiv_pkg::sqdiv_axil_rsp_t axil_rsp,
    output sqdiv_pkg::sqdiv_axil_req_t axil_req
);
    import sqdiv_pkg::*;

    initial begin
        axil_req = '0;
    end

    // ****************************************************************
    // bus cycles
    // ****************************************************************
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] resp);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge ref_clk);
        axil_req.awaddr <= a;
        axil_req.awvalid <= 1'b1;
        axil_req.wdata <= d;
        axil_req.wstrb <= 4'hf;
        axil_req.wvalid <= 1'b1;
        axil_req.bready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (!aw_done && axil_rsp.awready) begin
                aw_done = 1;
                axil_req.awvalid <= 1'b0;
            end
            if (!w_done && axil_rsp.wready) begin
                w_done = 1;
                axil_req.wvalid <= 1'b0;
            end
            if (axil_rsp.bvalid) begin
                resp = axil_rsp.bresp;
                axil_req.bready <= 1'b0;
                break;
            end
        end
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        bit ar_done;
        ar_done = 0;
        @(posedge ref_clk);
        axil_req.araddr <= a;
        axil_req.arvalid <= 1'b1;
        axil_req.rready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (!ar_done && axil_rsp.arready) begin
                ar_done = 1;
                axil_req.arvalid <= 1'b0;
            end
            if (axil_rsp.rvalid) begin
                d = axil_rsp.rdata;
                resp = axil_rsp.rresp;
                axil_req.rready <= 1'b0;
                break;
            end
        end
    endtask : read_reg

    // ****************************************************************
    // programming sequences
    // ****************************************************************
    // counter 0, low then high byte, square wave, binary
    task automatic program_mode(output logic [1:0] resp);
        write_reg(CTRL_OFFSET, 32'h0000_0034, resp);
    endtask : program_mode

    // counts below two give no usable wave, so they are never sent
    task automatic program_count(input logic [15:0] n,
                                 output logic [1:0] resp);
        logic [1:0] r_lo;
        logic [1:0] r_hi;
        resp = RESP_OKAY;
        if (n < 16'h0002) begin
            return;
        end
        write_reg(LOAD_OFFSET, {24'h0, n[7:0]}, r_lo);
        write_reg(LOAD_OFFSET, {24'h0, n[15:8]}, r_hi);
        resp = r_lo | r_hi;
    endtask : program_count
endmodule : sqdiv_host_model

// File: test_square_wave_divider_counter.sv
// testbench for the square-wave divider channel: programs it through the
// host model and times the output halves against the count.
// assumes the channel top and the host model are compiled before it.
`timescale 1ns/100ps
module test_square_wave_divider_counter;
    import sqdiv_pkg::*;

    logic ref_clk;
    logic reset;
    logic count_gate;
    logic timer_output;
    sqdiv_axil_req_t axil_req;
    sqdiv_axil_rsp_t axil_rsp;
    int n_errors;
    int total_checks;
    int cyc;

    sqdiv_channel u_sqdiv_channel (
        .ref_clk(ref_clk),
        .reset(reset),
        .axil_req(axil_req),
        .axil_rsp(axil_rsp),
        .count_gate(count_gate),
        .timer_output(timer_output)
    );

    sqdiv_host_model u_sqdiv_host_model (
        .ref_clk(ref_clk),
        .reset(reset),
        .axil_rsp(axil_rsp),
        .axil_req(axil_req)
    );

    // ****************************************************************
    // clock, timeout and helpers
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // the longest test is a 10000 count, so 30000 cycles is ample
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : tick

    // cycles until the output leaves its present level
    task automatic run_len(output int n);
        logic v;
        #1;
        v = timer_output;
        n = 0;
        while (timer_output === v && n < 20000) begin
            tick(1);
            n = n + 1;
        end
    endtask : run_len

    // returns just after a rising edge of the output
    task automatic sync_rise();
        int n;
        if (timer_output === 1'b1) begin
            run_len(n);
        end
        run_len(n);
    endtask : sync_rise

    task automatic status(output logic [31:0] s);
        logic [1:0] r;
        u_sqdiv_host_model.read_reg(STATUS_OFFSET, s, r);
    endtask : status

    task automatic set_gate(input logic v);
        @(posedge ref_clk);
        count_gate <= v;
    endtask : set_gate

    // ****************************************************************
    // main sequence
    // ****************************************************************
    localparam logic [15:0] COUNTS [3] = '{16'h0007, 16'h0006, 16'h0003};
    initial begin
        logic [31:0] d;
        logic [31:0] s1;
        logic [31:0] s2;
        logic [1:0] r;
        int n;
        int c0;
        n_errors = 0;
        total_checks = 0;
        cyc = 0;
        count_gate = 1'b0;
        reset = 1'b1;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        tick(1);
        check(timer_output, 1'b1);
        u_sqdiv_host_model.program_mode(r);
        check(r, RESP_OKAY);
        u_sqdiv_host_model.read_reg(CTRL_OFFSET, d, r);
        check(d[7:0], 8'h34);
        u_sqdiv_host_model.read_reg(8'h0c, d, r);
        check(r, RESP_SLVERR);
        check(d, 32'h0);
        u_sqdiv_host_model.write_reg(STATUS_OFFSET, 32'h1, r);
        check(r, RESP_SLVERR);
        // half a count written: a gate rise must not start anything
        u_sqdiv_host_model.write_reg(LOAD_OFFSET, 32'h10, r);
        set_gate(1'b1);
        tick(8);
        status(s1);
        check({s1[ST_PTR_BIT], s1[ST_VALID_BIT]}, 2'b10);
        check(timer_output, 1'b1);
        u_sqdiv_host_model.write_reg(LOAD_OFFSET, 32'h27, r);
        run_len(n);
        check(n, 5000);
        run_len(n);
        check(n, 5000);
        run_len(n);
        check(n, 5000);
        u_sqdiv_host_model.read_reg(LOAD_OFFSET, d, r);
        check(d[15:0], 16'h2710);
        foreach (COUNTS[i]) begin
            u_sqdiv_host_model.program_count(COUNTS[i], r);
            sync_rise();
            run_len(n);
            check(n, (COUNTS[i] + 1) / 2);
            run_len(n);
            check(n, COUNTS[i] / 2);
        end
        // freeze in a low half, then retrigger
        u_sqdiv_host_model.program_count(16'd40, r);
        sync_rise();
        run_len(n);
        check(n, 20);
        set_gate(1'b0);
        tick(5);
        status(s1);
        tick(10);
        status(s2);
        check(s2[31:16], s1[31:16]);
        check({s2[ST_OUT_BIT], timer_output}, 2'b00);
        set_gate(1'b1);
        run_len(n);
        // two sync flops, then the reload edge
        check(n, 3);
        run_len(n);
        check(n, 20);
        // new count mid half: old half finishes, then output stays high
        sync_rise();
        c0 = cyc;
        u_sqdiv_host_model.program_count(16'd6, r);
        run_len(n);
        check(cyc - c0, 23);
        run_len(n);
        check(n, 3);
        // a control word for another counter is not stored
        u_sqdiv_host_model.write_reg(CTRL_OFFSET, 32'hb4, r);
        u_sqdiv_host_model.read_reg(CTRL_OFFSET, d, r);
        check(d[7:0], 8'h34);
        // low-byte-only access: one write makes a whole count
        u_sqdiv_host_model.write_reg(CTRL_OFFSET, 32'h14, r);
        u_sqdiv_host_model.write_reg(LOAD_OFFSET, 32'h04, r);
        run_len(n);
        check(n, 2);
        run_len(n);
        check(n, 2);
        stop_test();
    end
endmodule : test_square_wave_divider_counter
